// ---- hdl/timer8_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer8_top
  import timer8_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_tick,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_pending_clear,
  input wire logic i_timer_vector_enable,
  input wire logic i_global_irq_enable,
  output logic o_cpu_pending_flag,
  output logic o_irq_req,
  output logic o_dma_trig_ch_zero,
  output logic o_dma_trig_ch_one,
  input wire logic [1:0] i_ch_pin,
  output logic [1:0] o_ch_pin,
  output logic [1:0] o_ch_oe
);
  logic [7:0] ctl_q, ctl_d, cnt_q, cnt_d, rdata_q, rdata_d;
  logic [6:0] pre_q, pre_d, pre_mask;
  logic [2:0] flags_q, flags_d, evt, masked;
  logic up_q, up_d, pend_q, pend_d, irq_q, irq_d;
  logic [1:0] dma_q;
  logic run, step, ovf, clr, wr_ctl;
  logic [7:0] cctl0, cctl1, cc0, cc1;
  logic [1:0] pin, ch_evt;
  count_mode_t mode;

  assign wr_ctl = i_sfr_wr && i_sfr_addr == ADDR_CTL;
  assign clr = wr_ctl && i_sfr_wdata[CTL_CLR];
  assign run = ctl_q[CTL_RUN];
  assign mode = count_mode_t'(ctl_q[1:0]);
  assign pre_mask = 7'((8'h01 << ctl_q[7:5]) - 8'h01);
  assign step = run && i_tick && ((pre_q & pre_mask) == pre_mask); // RL10 RL11

  // Prescaler: counts ticks while running; the active edge is when the low bits are all ones.
  always_comb begin
    pre_d = pre_q;
    if (clr) begin
      pre_d = 7'h00;
    end else if (run && i_tick) begin
      pre_d = pre_q + 7'h01; // RL10
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    up_d = up_q;
    ovf = 1'b0;
    if (step) begin
      unique case (mode) // RL13
        MODE_FREE: begin
          cnt_d = cnt_q + 8'h01;
          ovf = cnt_q == COUNT_TOP;
        end
        MODE_DOWN: begin
          if (cnt_q != COUNT_RESET) begin
            cnt_d = cnt_q - 8'h01;
            ovf = cnt_q == 8'h00_01;
          end
        end
        MODE_MOD: begin
          if (cnt_q == cc0) begin
            cnt_d = COUNT_RESET;
          end else begin
            cnt_d = cnt_q + 8'h01;
            ovf = cnt_q == COUNT_TOP;
          end
        end
        MODE_UPDN: begin
          if (up_q && cnt_q < cc0) begin
            cnt_d = cnt_q + 8'h01;
          end else if (cnt_q == COUNT_RESET) begin
            up_d = 1'b1;
          end else begin
            up_d = cnt_q == 8'h00_01;
            cnt_d = cnt_q - 8'h01;
            ovf = cnt_q == 8'h00_01; // RL22
          end
        end
      endcase
    end
    if (wr_ctl && !run && i_sfr_wdata[CTL_RUN] && i_sfr_wdata[1:0] == MODE_DOWN) begin
      cnt_d = cc0; // RL13
    end
    if (clr) begin
      cnt_d = COUNT_RESET; // RL12
      up_d = 1'b1; // RL22
    end
  end

  // The clear bit is a strobe and never stored.
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d = i_sfr_wdata;
      ctl_d[CTL_CLR] = 1'b0; // RL12
    end
  end

  assign evt = {ch_evt[1], ch_evt[0], ovf}; // RL3
  assign masked = {cctl1[CCTL_IM], cctl0[CCTL_IM], ctl_q[CTL_OVERFLOW_IRQ_MASK]}; // RL5 RL14

  // Software writes zero to clear a flag; a new event in the same cycle wins.
  always_comb begin
    flags_d = flags_q;
    pend_d = pend_q;
    if (i_sfr_wr && i_sfr_addr == ADDR_FLAGS) begin
      flags_d = flags_q & i_sfr_wdata[2:0];
      if (|(flags_q & ~i_sfr_wdata[2:0]) && |(flags_d & masked)) begin
        pend_d = 1'b1; // RL6
      end
    end
    flags_d = flags_d | evt; // RL4
    if (i_pending_clear) begin
      pend_d = 1'b0;
    end
    if (|(evt & masked)) begin
      pend_d = 1'b1; // RL2 RL5
    end
    irq_d = pend_d && !pend_q && i_timer_vector_enable && i_global_irq_enable; // RL7
  end

  always_comb begin
    unique case (i_sfr_addr)
      ADDR_COUNT: rdata_d = cnt_q; // RL9
      ADDR_CTL: rdata_d = ctl_q;
      ADDR_CCTL0: rdata_d = cctl0;
      ADDR_CC0: rdata_d = cc0;
      ADDR_CCTL1: rdata_d = cctl1;
      ADDR_CC1: rdata_d = cc1;
      ADDR_FLAGS: rdata_d = {5'h00, flags_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctl_q <= CTL_RESET; // RL11
      cnt_q <= COUNT_RESET; // RL9
      pre_q <= 7'h00;
      up_q <= 1'b1;
      flags_q <= 3'h0;
      pend_q <= 1'b0;
      irq_q <= 1'b0;
      dma_q <= 2'h0;
      rdata_q <= 8'h00;
    end else begin
      ctl_q <= ctl_d;
      cnt_q <= cnt_d;
      pre_q <= pre_d;
      up_q <= up_d;
      flags_q <= flags_d;
      pend_q <= pend_d;
      irq_q <= irq_d;
      dma_q <= ch_evt; // RL8 RL24
      rdata_q <= rdata_d;
    end
  end

  timer8_channel u_ch0 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_count(cnt_q),
    .i_step(step),
    .i_up(up_q),
    .i_updown(mode == MODE_UPDN),
    .i_run(run),
    .i_init(clr),
    .i_wr_ctl(i_sfr_wr && i_sfr_addr == ADDR_CCTL0),
    .i_wr_val(i_sfr_wr && i_sfr_addr == ADDR_CC0),
    .i_wdata(i_sfr_wdata),
    .i_cap_pin(i_ch_pin[0]),
    .o_ctl(cctl0),
    .o_val(cc0),
    .o_pin(pin[0]),
    .o_event(ch_evt[0])
  );

  timer8_channel u_ch1 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_count(cnt_q),
    .i_step(step),
    .i_up(up_q),
    .i_updown(mode == MODE_UPDN),
    .i_run(run),
    .i_init(clr),
    .i_wr_ctl(i_sfr_wr && i_sfr_addr == ADDR_CCTL1),
    .i_wr_val(i_sfr_wr && i_sfr_addr == ADDR_CC1),
    .i_wdata(i_sfr_wdata),
    .i_cap_pin(i_ch_pin[1]),
    .o_ctl(cctl1),
    .o_val(cc1),
    .o_pin(pin[1]),
    .o_event(ch_evt[1])
  );

  assign o_sfr_rdata = rdata_q;
  assign o_cpu_pending_flag = pend_q;
  assign o_irq_req = irq_q;
  assign o_dma_trig_ch_zero = dma_q[0];
  assign o_dma_trig_ch_one = dma_q[1];
  assign o_ch_pin = pin;
  assign o_ch_oe = {cctl1[CCTL_FUNC], cctl0[CCTL_FUNC]};

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence clr_write;
    i_sfr_wr && i_sfr_addr == ADDR_CTL && i_sfr_wdata[CTL_CLR];
  endsequence

  sequence free_top_step;
    step && mode == MODE_FREE && cnt_q == COUNT_TOP;
  endsequence

  clear_count_a: assert property (clr_write |=> cnt_q == 8'h00 && up_q) // RL12
    else $error("clear did not zero the counter");
  clr_reads_a: assert property (i_sfr_addr == ADDR_CTL |=> o_sfr_rdata[CTL_CLR] == 1'b0) // RL12
    else $error("clear bit read back as one");
  count_freeze_a: assert property (!run && !clr && !wr_ctl |=> cnt_q == $past(cnt_q)) // RL11
    else $error("counter moved while stopped");
  free_wrap_a: assert property (free_top_step |=> cnt_q == 8'h00 && flags_q[FLAG_OVF]) // RL13
    else $error("free-running wrap missing");
  flag_nomask_a: assert property (ovf && !ctl_q[CTL_OVERFLOW_IRQ_MASK] |=> flags_q[FLAG_OVF]) // RL4
    else $error("flag not set while masked out");
  pend_mask_a: assert property (ovf && ctl_q[CTL_OVERFLOW_IRQ_MASK] |=> o_cpu_pending_flag) // RL5
    else $error("pending flag not set");
  irq_edge_a: assert property (o_irq_req |-> pend_q && !$past(pend_q)) // RL7
    else $error("request without pending rise");
  dma_flag_a: assert property (ch_evt[0] |=> o_dma_trig_ch_zero && flags_q[FLAG_CH0] ##1 (!o_dma_trig_ch_zero || $past(ch_evt[0]))) // RL24
    else $error("dma trigger not aligned with flag");
  count_read_a: assert property (i_sfr_addr == ADDR_COUNT |=> o_sfr_rdata == $past(cnt_q)) // RL9
    else $error("counter read mismatch");
endmodule
`default_nettype wire

// ---- hdl/timer8_pkg.sv ----
// Function
// RL1 - Initialised compare output is 0 for actions 000,010,011,101; 1 for 001,100,110.
// RL2 - One interrupt output reports overflow, compare and capture events of this timer.
// RL3 - Terminal count, compare match and capture are the interrupt events.
// RL4 - Source flags sit in one shared register, set regardless of masks.
// RL5 - Pending flag sets only for masked-in sources; overflow mask is control bit 3.
// RL6 - Clearing one flag re-sets pending while another enabled flag stays set.
// RL7 - Interrupt request only on pending rise with both enables high.
// RL8 - Two DMA triggers, one per channel, on capture or compare events.
// RL9 - Counter register is read-only, eight bits, resets to zero, reads live.
// RL10 - Prescale field 7:5 divides the tick by two to the field value.
// RL11 - Run bit 4 resets low; set counts, cleared freezes the counter.
// RL12 - Writing clear bit 2 zeroes counter, initialises outputs; reads as zero.
// RL13 - Modes: free-running, down from channel 0, modulo, up/down to channel 0.
// RL14 - Channel control bit 6 is the interrupt mask, reset value one.
// RL15 - Compare action field 5:3 selects set, clear, toggle and paired actions.
// RL16 - Up/down counting: actions 011 and 100 act by match direction.
// RL17 - Writing action 111 initialises the pin and keeps the stored action.
// RL18 - Channel bit 2 selects capture when 0 and compare when 1.
// RL19 - Capture edge field 1:0 selects none, rising, falling or both edges.
// RL20 - A written compare value takes effect when the counter next is zero.
// RL21 - Selected capture edge copies the counter and sets the channel flag.
// RL22 - Up/down flags terminal count at zero; clear restores upward counting.
// RL23 - Capture pulses must last longer than one system clock period.
// RL24 - Each DMA trigger is one-cycle, coincident with its flag becoming set.
// RL25 - Channel control bit 7 ignores writes and reads as zero.
package timer8_pkg;
  localparam logic [7:0] ADDR_COUNT = 8'h00_CA;
  localparam logic [7:0] ADDR_CTL = 8'h00_CB;
  localparam logic [7:0] ADDR_CCTL0 = 8'h00_CC;
  localparam logic [7:0] ADDR_CC0 = 8'h00_CD;
  localparam logic [7:0] ADDR_CCTL1 = 8'h00_CE;
  localparam logic [7:0] ADDR_CC1 = 8'h00_CF;
  localparam logic [7:0] ADDR_FLAGS = 8'h00_D8;
  localparam int CTL_DIV_LSB = 5;
  localparam int CTL_RUN = 4;
  localparam int CTL_OVERFLOW_IRQ_MASK = 3;
  localparam int CTL_CLR = 2;
  localparam int CCTL_IM = 6;
  localparam int CCTL_CMP_LSB = 3;
  localparam int CCTL_FUNC = 2;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CH0 = 1;
  localparam int FLAG_CH1 = 2;
  localparam logic [7:0] CTL_RESET = 8'h00_08;
  localparam logic [7:0] CCTL_RESET = 8'h00_40;
  localparam logic [7:0] COUNT_RESET = 8'h00_00;
  localparam logic [7:0] COUNT_TOP = 8'h00_FF;
  localparam logic [2:0] CMP_INIT = 3'h7;
  typedef enum logic [1:0] {
    MODE_FREE = 2'h0,
    MODE_DOWN = 2'h1,
    MODE_MOD = 2'h2,
    MODE_UPDN = 2'h3
  } count_mode_t;
endpackage

// ---- hdl/timer8_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer8_channel
  import timer8_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [7:0] i_count,
  input wire logic i_step,
  input wire logic i_up,
  input wire logic i_updown,
  input wire logic i_run,
  input wire logic i_init,
  input wire logic i_wr_ctl,
  input wire logic i_wr_val,
  input wire logic [7:0] i_wdata,
  input wire logic i_cap_pin,
  output logic [7:0] o_ctl,
  output logic [7:0] o_val,
  output logic o_pin,
  output logic o_event
);
  logic [6:0] ctl_q, ctl_d;
  logic [7:0] val_q, val_d, pend_q, pend_d;
  logic pend_v_q, pend_v_d, pin_q, pin_d;
  logic [2:0] sync_q;
  logic [2:0] act;
  logic cmp_mode, match, rise, fall, cap;
  logic init_lvl;

  assign act = ctl_q[5:3];
  assign cmp_mode = ctl_q[CCTL_FUNC]; // RL18
  assign rise = sync_q[1] & ~sync_q[2];
  assign fall = ~sync_q[1] & sync_q[2];
  assign cap = ~cmp_mode & i_run & ((ctl_q[0] & rise) | (ctl_q[1] & fall)); // RL19 RL21 RL23
  assign match = cmp_mode & i_step & (i_count == val_q);
  assign o_event = cap | match;
  assign o_ctl = {1'b0, ctl_q}; // RL25
  assign o_val = val_q;
  assign o_pin = pin_q;
  assign init_lvl = (act == 3'h1) | (act == 3'h4) | (act == 3'h6); // RL1

  always_comb begin
    ctl_d = ctl_q;
    val_d = val_q;
    pend_d = pend_q;
    pend_v_d = pend_v_q;
    pin_d = pin_q;
    if (i_wr_ctl) begin
      ctl_d[6] = i_wdata[6];
      ctl_d[2:0] = i_wdata[2:0];
      if (i_wdata[5:3] != CMP_INIT) begin
        ctl_d[5:3] = i_wdata[5:3]; // RL17
      end
    end
    if (cap) begin
      val_d = i_count; // RL21
    end
    if (pend_v_q && i_count == COUNT_RESET) begin
      val_d = pend_q; // RL20
      pend_v_d = 1'b0;
    end
    if (i_wr_val) begin
      if (cmp_mode) begin
        pend_d = i_wdata; // RL20
        pend_v_d = 1'b1;
      end else begin
        val_d = i_wdata;
      end
    end
    if (cmp_mode && i_step) begin
      unique case (act)
        3'h0: if (match) pin_d = 1'b1; // RL15
        3'h1: if (match) pin_d = 1'b0;
        3'h2: if (match) pin_d = ~pin_q;
        3'h3: begin
          if (match) pin_d = i_updown ? i_up : 1'b1; // RL16
          else if (!i_updown && i_count == COUNT_RESET) pin_d = 1'b0;
        end
        3'h4: begin
          if (match) pin_d = i_updown ? ~i_up : 1'b0; // RL16
          else if (!i_updown && i_count == COUNT_RESET) pin_d = 1'b1;
        end
        3'h5: begin
          if (match) pin_d = 1'b1;
          else if (i_count == COUNT_TOP) pin_d = 1'b0;
        end
        3'h6: begin
          if (match) pin_d = 1'b0;
          else if (i_count == COUNT_RESET) pin_d = 1'b1;
        end
        3'h7: pin_d = pin_q;
      endcase
    end
    if (i_init || (i_wr_ctl && i_wdata[5:3] == CMP_INIT)) begin
      pin_d = init_lvl; // RL1 RL12 RL17
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctl_q <= CCTL_RESET[6:0]; // RL14
      val_q <= COUNT_RESET;
      pend_q <= COUNT_RESET;
      pend_v_q <= 1'b0;
      pin_q <= 1'b0;
      sync_q <= 3'h0;
    end else begin
      ctl_q <= ctl_d;
      val_q <= val_d;
      pend_q <= pend_d;
      pend_v_q <= pend_v_d;
      pin_q <= pin_d;
      sync_q <= {sync_q[1:0], i_cap_pin};
    end
  end

  init_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_init |=> o_pin == $past(init_lvl)) else $error("pin not initialised"); // RL1
endmodule
`default_nettype wire

// ---- sim/timer8_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer8_pin_model (
  input wire logic i_clk_sys,
  output logic [1:0] o_pin
);
  initial begin
    o_pin = 2'h0;
  end

  // Each level is held for three clocks so the input synchroniser always sees it.
  task automatic drive(input int ch, input logic v);
    @(posedge i_clk_sys);
    #1;
    o_pin[ch] = v;
    repeat (3) @(posedge i_clk_sys);
  endtask
endmodule
`default_nettype wire

// ---- sim/timer8_two_channel_capture_compare_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer8_two_channel_capture_compare_tb;
  import timer8_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tick = 1'b0;
  logic wr = 1'b0;
  logic pclr = 1'b0;
  logic ven = 1'b1;
  logic gen = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic pend, irq, dma0, dma1;
  logic [1:0] cap, pin, oe;
  int bad_count = 0;
  int samples_checked = 0;
  int irq_n = 0;
  int dma0_n = 0;
  int dma1_n = 0;
  int cyc = 0;
  logic [1:0] md [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  int tn [4] = '{2, 4, 6, 256};
  logic [7:0] ce [4] = '{8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0] fl [4] = '{8'h00, 8'h00, 8'h01, 8'h01};
  localparam logic [6:0] INIT_TBL = 7'h52;

  initial begin
    forever #2.5 clk = ~clk;
  end

  timer8_top timer8_top_i (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_tick(tick), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_pending_clear(pclr),
    .i_timer_vector_enable(ven), .i_global_irq_enable(gen), .o_cpu_pending_flag(pend),
    .o_irq_req(irq), .o_dma_trig_ch_zero(dma0), .o_dma_trig_ch_one(dma1),
    .i_ch_pin(cap), .o_ch_pin(pin), .o_ch_oe(oe)
  );

  timer8_pin_model timer8_pin_model_i (.i_clk_sys(clk), .o_pin(cap));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    irq_n += int'(irq);
    dma0_n += int'(dma0);
    dma1_n += int'(dma1);
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    step();
    addr = a;
    wdata = d;
    wr = 1'b1;
    step();
    wr = 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    step();
    addr = a;
    step();
    chk(rdata, e);
  endtask

  task automatic ticks(input int n);
    step();
    tick = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    tick = 1'b0;
  endtask

  task automatic pulse(input int ch);
    timer8_pin_model_i.drive(ch, 1'b1);
    timer8_pin_model_i.drive(ch, 1'b0);
    repeat (5) step();
  endtask

  task automatic ack();
    step();
    pclr = 1'b1;
    step();
    pclr = 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rchk(ADDR_CTL, CTL_RESET);
    rchk(ADDR_CCTL0, CCTL_RESET);
    rchk(ADDR_CCTL1, CCTL_RESET);
    rchk(ADDR_COUNT, COUNT_RESET);
    rchk(8'h00, 8'h00);
    wr_reg(ADDR_COUNT, 8'h55);
    rchk(ADDR_COUNT, COUNT_RESET);
    wr_reg(ADDR_CCTL1, 8'hC0);
    rchk(ADDR_CCTL1, 8'h40);
    wr_reg(ADDR_CTL, 8'h0C);
    rchk(ADDR_CTL, 8'h08);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      wr_reg(ADDR_CTL, {k[2:0], 5'h1C});
      ticks(3 << k);
      rchk(ADDR_COUNT, 8'h03);
    end
    wr_reg(ADDR_CTL, 8'hE8);
    ticks(10);
    rchk(ADDR_COUNT, 8'h03);
    $display("test prescaler done");
    wr_reg(ADDR_CTL, 8'hF8);
    for (int c = 0; c < 4; c++) begin
      wr_reg(ADDR_FLAGS, 8'h00);
      wr_reg(ADDR_CCTL0, 8'h40 | 8'(c));
      dma0_n = 0;
      pulse(0);
      chk(8'(dma0_n), 8'((c + 1) / 2));
      rchk(ADDR_FLAGS, (c == 0) ? 8'h00 : 8'h02);
    end
    rchk(ADDR_CC0, 8'h03);
    $display("test capture done");
    wr_reg(ADDR_CCTL0, 8'h41);
    wr_reg(ADDR_CCTL1, 8'h01);
    wr_reg(ADDR_FLAGS, 8'h00);
    ack();
    irq_n = 0;
    pulse(1);
    chk(8'(pend), 8'h00);
    rchk(ADDR_FLAGS, 8'h04);
    wr_reg(ADDR_CCTL1, 8'h41);
    pulse(0);
    chk(8'(pend), 8'h01);
    chk(8'(irq_n), 8'h01);
    pulse(1);
    ack();
    chk(8'(pend), 8'h00);
    gen = 1'b0;
    wr_reg(ADDR_FLAGS, 8'hFD);
    step();
    chk(8'(pend), 8'h01);
    chk(8'(irq_n), 8'h01);
    gen = 1'b1;
    $display("test interrupts done");
    wr_reg(ADDR_CCTL0, 8'h40);
    wr_reg(ADDR_CC0, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_FLAGS, 8'h00);
      wr_reg(ADDR_CTL, {6'h01, md[i]});
      wr_reg(ADDR_CTL, {6'h04, md[i]});
      ticks(tn[i]);
      rchk(ADDR_COUNT, ce[i]);
      rchk(ADDR_FLAGS, fl[i]);
    end
    $display("test modes done");
    for (int a = 0; a < 7; a++) begin
      wr_reg(ADDR_CCTL1, 8'h44 | 8'(a << 3));
      wr_reg(ADDR_CCTL1, 8'h7C);
      step();
      chk(8'(pin[1]), 8'(INIT_TBL[a]));
      chk(8'(oe[1]), 8'h01);
      rchk(ADDR_CCTL1, 8'h44 | 8'(a << 3));
    end
    wr_reg(ADDR_CCTL1, 8'h44);
    wr_reg(ADDR_CC1, 8'h05);
    wr_reg(ADDR_CTL, 8'h04);
    step();
    wr_reg(ADDR_CTL, 8'h10);
    dma1_n = 0;
    ticks(4);
    step();
    chk(8'(pin[1]), 8'h00);
    ticks(2);
    step();
    chk(8'(pin[1]), 8'h01);
    chk(8'(dma1_n), 8'h01);
    wr_reg(ADDR_CC1, 8'h09);
    rchk(ADDR_CC1, 8'h05);
    wr_reg(ADDR_CTL, 8'h04);
    rchk(ADDR_CC1, 8'h09);
    $display("test compare done");
    stop_test();
  end
endmodule
`default_nettype wire
